// ---- hdl/rx_modem_config_regs.sv ----
// Modem configuration register bank with derived demodulator controls.
`include "rx_modem_defines.svh"
module rx_modem_config_regs
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  input  wire logic [5:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic [21:0] base_frequency_i,
  input  wire logic [15:0] sync_word_i,
  input  wire logic [31:0] rx_bits_i,
  input  wire logic        carrier_sense_i,
  output logic [7:0]       reg_rdata_o,
  output logic             dc_block_bypass_o,
  output logic [2:0]       modulation_select_o,
  output logic             manchester_enable_o,
  output logic [2:0]       deviation_exponent_o,
  output logic [2:0]       deviation_mantissa_o,
  output logic             deviation_valid_o,
  output logic [31:0]      rx_frequency_o,
  output logic             sync_detect_o
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    rx_modem_pkg::format_t format;
    logic [7:0]            spc_exp;
    logic [7:0]            spc_mant;
    logic [7:0]            deviation;
    logic [7:0]            channel_index;
    logic [7:0]            rdata;
    logic [31:0]           rx_frequency;
    logic                  deviation_valid;
  } bank_t;

  bank_t state;
  bank_t next_state;
  logic  detect;

  // Spacing in units of the crystal over 2^18, so the 2^18 divide is a fixed scale.
  function automatic logic [11:0] spacing(input logic [7:0] m, input logic [1:0] e);
    logic [11:0] s;
    s = {3'h0, (`SPC_BASE + {1'b0, m})};
    return s << e;
  endfunction : spacing

  always_comb
  begin
    next_state = state;
    if (reg_write_i)
    begin
      unique case (reg_addr_i)
        `ADDR_FORMAT:    next_state.format = reg_wdata_i;
        `ADDR_SPC_EXP:   next_state.spc_exp = reg_wdata_i & `MASK_SPC_EXP;
        `ADDR_SPC_MANT:  next_state.spc_mant = reg_wdata_i;
        `ADDR_DEVIATION: next_state.deviation = reg_wdata_i & `MASK_DEVIATION;
        `ADDR_CHANNEL:   next_state.channel_index = reg_wdata_i;
        default:         next_state.rdata = state.rdata;
      endcase
    end
    if (reg_read_i)
    begin
      unique case (reg_addr_i)
        `ADDR_FORMAT:    next_state.rdata = state.format;
        `ADDR_SPC_EXP:   next_state.rdata = state.spc_exp;
        `ADDR_SPC_MANT:  next_state.rdata = state.spc_mant;
        `ADDR_DEVIATION: next_state.rdata = state.deviation;
        `ADDR_CHANNEL:   next_state.rdata = state.channel_index;
        default:         next_state.rdata = 8'h00;
      endcase
    end
    // Registered beside the format field so the output comes from a flop in the same cycle.
    next_state.deviation_valid = next_state.format.modulation_select != rx_modem_pkg::MOD_OOK;
    // Frequency in crystal/2^18 units: base word is in crystal/2^16 units.
    next_state.rx_frequency = {8'h00, base_frequency_i, 2'h0}
      + ({20'h00000, spacing(state.spc_mant, state.spc_exp[1:0])}
      * {24'h000000, state.channel_index});
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      state.format        <= `RST_FORMAT;
      state.spc_exp       <= `RST_SPC_EXP;
      state.spc_mant      <= `RST_SPC_MANT;
      state.deviation     <= `RST_DEVIATION;
      state.channel_index <= `RST_CHANNEL;
      state.rdata         <= 8'h00;
      state.rx_frequency  <= 32'h0000_0000;
      state.deviation_valid <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Sync qualifier
  // ----------------------------------------------------------------
  sync_qualifier u_sync
  (
    .clock_i         (clock_i),
    .nrst_i          (nrst_i),
    .sync_mode_i     (state.format.sync_mode),
    .sync_word_i     (sync_word_i),
    .rx_bits_i       (rx_bits_i),
    .carrier_sense_i (carrier_sense_i),
    .detect_o        (detect)
  );

  // Outputs are taken from flip-flops; the detect flop lives in the qualifier.
  assign reg_rdata_o          = state.rdata;
  assign dc_block_bypass_o    = state.format.dc_block_bypass;
  assign modulation_select_o  = state.format.modulation_select;
  assign manchester_enable_o  = state.format.manchester_enable;
  assign deviation_exponent_o = state.deviation[6:4];
  assign deviation_mantissa_o = state.deviation[2:0];
  // Deviation has no effect with OOK.
  assign deviation_valid_o    = state.deviation_valid;
  assign rx_frequency_o       = state.rx_frequency;
  assign sync_detect_o        = detect;
endmodule : rx_modem_config_regs

// ---- hdl/rx_modem_defines.svh ----
// Offsets, field positions, reset values and rule summary for the modem configuration bank.
// How it works
// - Bit 7 of format register bypasses the DC blocking filter when set.
// - Bits 6:4 select 2-FSK, GFSK, OOK or 4-FSK; others reserved.
// - Bit 3 enables Manchester decoding; host keeps it clear in synchronous mode.
// - Sync qualifier 000 disables preamble and sync detection; 100 detects on carrier sense alone.
// - Qualifier 001 or 101 accepts 16-bit sync word with 15 matching bits.
// - Qualifier 010 or 110 needs all 16 sync bits matching.
// - Qualifier 011 or 111 uses doubled 32-bit sync word, 30 bits matching.
// - Qualifiers 100 to 111 also require carrier sense above threshold.
// - Spacing exponent in bits 1:0; bits 6:2 unused and read zero.
// - Spacing is crystal over 2^18 times (256 plus mantissa) times 2^exponent.
// - Receive frequency is base plus spacing times channel number.
// - Deviation exponent bits 6:4, mantissa bits 2:0; bits 7 and 3 unused.
// - Deviation settings are ignored when OOK is selected.
// - Channel number is an 8-bit unsigned value in its own register.
`ifndef RX_MODEM_DEFINES_SVH
`define RX_MODEM_DEFINES_SVH
`define ADDR_CHANNEL   6'h0A
`define ADDR_FORMAT    6'h12
`define ADDR_SPC_EXP   6'h13
`define ADDR_SPC_MANT  6'h14
`define ADDR_DEVIATION 6'h15
`define RST_CHANNEL    8'h00
`define RST_FORMAT     8'h02
`define RST_SPC_EXP    8'h02
`define RST_SPC_MANT   8'hF8
`define RST_DEVIATION  8'h47
`define MASK_SPC_EXP   8'h83
`define MASK_DEVIATION 8'h77
`define SPC_BASE       9'h100
`define SYNC16_MIN     6'h0F
`define SYNC32_MIN     6'h1E
`endif

// ---- hdl/rx_modem_pkg.sv ----
// Types shared by the modem configuration bank and its sync qualifier.
package rx_modem_pkg;
  typedef enum logic [2:0]
  {
    MOD_2FSK = 3'h0,
    MOD_GFSK = 3'h1,
    MOD_OOK  = 3'h3,
    MOD_4FSK = 3'h4
  } modulation_t;

  typedef struct packed
  {
    logic       dc_block_bypass;
    logic [2:0] modulation_select;
    logic       manchester_enable;
    logic [2:0] sync_mode;
  } format_t;

  typedef struct packed
  {
    logic [5:0] match_count;
    logic       detect;
  } sync_state_t;
endpackage : rx_modem_pkg

// ---- hdl/sync_qualifier.sv ----
// Sync-word qualifier: counts matching bits and combines with carrier sense.
`include "rx_modem_defines.svh"
module sync_qualifier
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic [2:0]  sync_mode_i,
  input  wire logic [15:0] sync_word_i,
  input  wire logic [31:0] rx_bits_i,
  input  wire logic        carrier_sense_i,
  output logic             detect_o
);
  rx_modem_pkg::sync_state_t state;
  rx_modem_pkg::sync_state_t next_state;

  function automatic logic [5:0] ones32(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++)
    begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction : ones32

  always_comb
  begin
    logic hit;
    hit = 1'b0;
    next_state = state;
    unique case (sync_mode_i[1:0])
      2'h0:
      begin
        next_state.match_count = 6'h00;
        hit = 1'b1;
      end
      2'h1:
      begin
        next_state.match_count = ones32({16'h0000, ~(rx_bits_i[15:0] ^ sync_word_i)});
        hit = next_state.match_count >= `SYNC16_MIN;
      end
      2'h2:
      begin
        next_state.match_count = ones32({16'h0000, ~(rx_bits_i[15:0] ^ sync_word_i)});
        hit = next_state.match_count == 6'h10;
      end
      2'h3:
      begin
        next_state.match_count = ones32(~(rx_bits_i ^ {sync_word_i, sync_word_i}));
        hit = next_state.match_count >= `SYNC32_MIN;
      end
    endcase
    // Mode 0 has no detection at all; mode 4 is carrier sense alone.
    if (sync_mode_i == 3'h0)
    begin
      next_state.detect = 1'b0;
    end
    else
    begin
      next_state.detect = hit & (~sync_mode_i[2] | carrier_sense_i);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign detect_o = state.detect;
endmodule : sync_qualifier

// ---- sim/host_model.sv ----
// Host model issuing byte register transfers.
module host_model
(
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  output logic [15:0]     bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus_o = 16'h0000;
  // Released address and data lines show the inverse, and both strobes drop to zero, so a stale byte cannot pass for a held one.
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clock_i);
    #1 bus_o = {w, !w, a, d};
    @(posedge clock_i);
    #1 q = rdata_i;
    bus_o = {2'b00, ~a, ~d};
  endtask : xfer
endmodule : host_model

// ---- sim/rx_modem_config_regs_test.sv ----
// Self-checking bench for the modem configuration bank.
module rx_modem_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0, nrst_i = 1'b0, carrier_sense_i = 1'b0;
  logic        reg_write_i, reg_read_i, dc_block_bypass_o, manchester_enable_o;
  logic        deviation_valid_o, sync_detect_o;
  logic [5:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, v, q;
  logic [2:0]  modulation_select_o, deviation_exponent_o, deviation_mantissa_o;
  logic [15:0] sync_word_i = 16'hB00F, bus;
  logic [21:0] base_frequency_i = 22'h12345;
  logic [31:0] rx_bits_i = 32'h0, rx_frequency_o, e;
  int          num_errors = 0, total_checks = 0, cycles = 0;
  assign {reg_write_i, reg_read_i, reg_addr_i, reg_wdata_i} = bus;
  host_model host (.clock_i(clock_i), .rdata_i(reg_rdata_o), .bus_o(bus));
  rx_modem_config_regs DUT
  (
    .clock_i              (clock_i),
    .nrst_i               (nrst_i),
    .reg_write_i          (reg_write_i),
    .reg_read_i           (reg_read_i),
    .reg_addr_i           (reg_addr_i),
    .reg_wdata_i          (reg_wdata_i),
    .base_frequency_i     (base_frequency_i),
    .sync_word_i          (sync_word_i),
    .rx_bits_i            (rx_bits_i),
    .carrier_sense_i      (carrier_sense_i),
    .reg_rdata_o          (reg_rdata_o),
    .dc_block_bypass_o    (dc_block_bypass_o),
    .modulation_select_o  (modulation_select_o),
    .manchester_enable_o  (manchester_enable_o),
    .deviation_exponent_o (deviation_exponent_o),
    .deviation_mantissa_o (deviation_mantissa_o),
    .deviation_valid_o    (deviation_valid_o),
    .rx_frequency_o       (rx_frequency_o),
    .sync_detect_o        (sync_detect_o)
  );
  initial forever #2.5 clock_i = ~clock_i;
  always @(posedge clock_i)
    if (++cycles == 3000)
    begin
      num_errors++;
      finish_test;
    end
  task automatic check(input logic [31:0] seen, want);
    total_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD %0t %h %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_map;
    logic [5:0] a [8] = '{6'h0A, 6'h12, 6'h13, 6'h14, 6'h15, 6'h13, 6'h15, 6'h20};
    logic [7:0] r [8] = '{8'h00, 8'h02, 8'h02, 8'hF8, 8'h47, 8'h83, 8'h77, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      if (i > 4)
        host.xfer(1'b1, a[i], 8'hFF, q);
      host.xfer(1'b0, a[i], 8'h00, q);
      check(q, r[i]);
    end
    check({deviation_exponent_o, deviation_mantissa_o}, 6'h3F);
  endtask : t_map
  task automatic t_mod;
    for (int i = 0; i < 8; i++)
    begin
      // Manchester follows i[1], so it never meets four-level FSK.
      // The IF word lives outside this bank; a real host rewrites it after each bit 7 toggle.
      v = {i[0], 3'(i), i[1], 3'h2};
      host.xfer(1'b1, 6'h12, v, q);
      host.xfer(1'b0, 6'h12, 8'h00, q);
      check(q, v);
      check({dc_block_bypass_o, modulation_select_o, manchester_enable_o}, v[7:3]);
      check(deviation_valid_o, i != 3);
    end
  endtask : t_mod
  task automatic t_freq;
    logic [7:0] c [2] = '{8'h05, 8'hFF};
    logic [7:0] m [2] = '{8'h10, 8'hFF};
    for (int i = 0; i < 2; i++)
    begin
      base_frequency_i = i ? 22'h3FFFFF : 22'h12345;
      host.xfer(1'b1, 6'h0A, c[i], q);
      host.xfer(1'b1, 6'h14, m[i], q);
      host.xfer(1'b1, 6'h13, 8'(2 * i + 1), q);
      e = {base_frequency_i, 2'b00} + ((32'h100 + m[i]) << (2 * i + 1)) * c[i];
      repeat (2) @(posedge clock_i);
      #1 check(rx_frequency_o, e);
    end
  endtask : t_freq
  task automatic t_sync;
    logic [55:0] md = 56'h01123345672457, fl = 56'h01212301000012;
    logic [55:0] cs = 56'h00000010100011, ex = 56'h01001010101011;
    for (int i = 0; i < 14; i++)
    begin
      host.xfer(1'b1, 6'h12, {5'h00, md[54 - 4 * i -: 3]}, q);
      rx_bits_i = {2{sync_word_i}} ^ ((32'h1 << fl[53 - 4 * i -: 2]) - 32'h1);
      carrier_sense_i = cs[52 - 4 * i];
      repeat (2) @(posedge clock_i);
      #1 check(sync_detect_o, ex[52 - 4 * i]);
    end
  endtask : t_sync
  initial
  begin
    repeat (10) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    t_map;
    t_mod;
    t_freq;
    t_sync;
    finish_test;
  end
endmodule : rx_modem_config_regs_test
bind rx_modem_config_regs rx_modem_props props
(
  .clock_i              (clock_i),
  .nrst_i               (nrst_i),
  .reg_write_i          (reg_write_i),
  .reg_addr_i           (reg_addr_i),
  .reg_wdata_i          (reg_wdata_i),
  .sync_word_i          (sync_word_i),
  .rx_bits_i            (rx_bits_i),
  .carrier_sense_i      (carrier_sense_i),
  .modulation_select_o  (modulation_select_o),
  .deviation_exponent_o (deviation_exponent_o),
  .deviation_mantissa_o (deviation_mantissa_o),
  .deviation_valid_o    (deviation_valid_o),
  .sync_detect_o        (sync_detect_o)
);

// ---- sim/rx_modem_props.sv ----
// Checker bound to the modem configuration bank.
`include "rx_modem_defines.svh"
module rx_modem_props
(
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        reg_write_i,
  input wire logic [5:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [15:0] sync_word_i,
  input wire logic [31:0] rx_bits_i,
  input wire logic        carrier_sense_i,
  input wire logic [2:0]  modulation_select_o,
  input wire logic [2:0]  deviation_exponent_o,
  input wire logic [2:0]  deviation_mantissa_o,
  input wire logic        deviation_valid_o,
  input wire logic        sync_detect_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] mode, pm;
  logic [7:0] wdata_q;
  logic       cs_q, fmt_wr, cs_ok;
  int         hit16, hit32;
  assign fmt_wr = reg_write_i && reg_addr_i == `ADDR_FORMAT;
  assign cs_ok = cs_q || !pm[2];
  // Mode is cleared in pm during reset, since the qualifier output is then zero.
  always_ff @(posedge clock_i)
  begin
    pm    <= nrst_i ? mode : 3'h0;
    cs_q  <= carrier_sense_i;
    wdata_q <= reg_wdata_i;
    hit16 <= $countones(~(rx_bits_i[15:0] ^ sync_word_i));
    hit32 <= $countones(~(rx_bits_i ^ {2{sync_word_i}}));
    mode  <= !nrst_i ? 3'h2 : fmt_wr ? reg_wdata_i[2:0] : mode;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_fmt; fmt_wr |=> modulation_select_o == wdata_q[6:4]; endproperty
  a_fmt: assert property (p_fmt) else $error("modulation field");
  property p_dev; reg_write_i && reg_addr_i == `ADDR_DEVIATION |=>
    {deviation_exponent_o, deviation_mantissa_o} == {wdata_q[6:4], wdata_q[2:0]};
  endproperty
  a_dev: assert property (p_dev) else $error("deviation fields");
  property p_ook; deviation_valid_o == (modulation_select_o != 3'h3); endproperty
  a_ook: assert property (p_ook) else $error("deviation valid");
  property p_none; pm == 3'h0 |-> !sync_detect_o; endproperty
  a_none: assert property (p_none) else $error("detect while off");
  property p_cs; pm == 3'h4 |-> sync_detect_o == cs_q; endproperty
  a_cs: assert property (p_cs) else $error("carrier sense only");
  property p_s15; pm[1:0] == 2'h1 |-> sync_detect_o == (hit16 >= 15 && cs_ok); endproperty
  a_s15: assert property (p_s15) else $error("sync 15 of 16");
  property p_s16; pm[1:0] == 2'h2 |-> sync_detect_o == (hit16 == 16 && cs_ok); endproperty
  a_s16: assert property (p_s16) else $error("sync 16 of 16");
  property p_s32; pm[1:0] == 2'h3 |-> sync_detect_o == (hit32 >= 30 && cs_ok); endproperty
  a_s32: assert property (p_s32) else $error("sync 30 of 32");
  c_fmt: cover property (fmt_wr);
  c_det: cover property (sync_detect_o);
  c_ook: cover property (!deviation_valid_o);
endmodule : rx_modem_props
